// ===== shared/cmp_pkg.sv
// shared constants and types for the triple comparator control block
package cmp_pkg;

  // register byte offsets
  localparam logic [15:0] status_off = 16'h2300;
  localparam logic [15:0] chan1_off = 16'h2310;
  localparam logic [15:0] chan2_off = 16'h2330;
  localparam logic [15:0] chan3_off = 16'h2350;
  localparam logic [15:0] refgen_off = 16'h2360;

  // alias offsets added to a register base
  localparam logic [3:0] alias_plain = 4'h0;
  localparam logic [3:0] alias_clear = 4'h4;
  localparam logic [3:0] alias_set = 4'h8;
  localparam logic [3:0] alias_invert = 4'hc;

  // reset value shared by all registers
  localparam logic [31:0] reg_reset = 32'h0000_0000;

  // channel control field positions
  localparam int ctl_enable_bit = 15;
  localparam int ctl_pin_oe_bit = 14;
  localparam int ctl_polarity_bit = 13;
  localparam int ctl_event_bit = 9;
  localparam int ctl_output_bit = 8;
  localparam int ctl_edge_lo = 6;
  localparam int ctl_pos_sel_bit = 4;
  localparam int ctl_neg_sel_lo = 0;
  // writable channel control bits (event and output flags are hardware owned)
  localparam logic [31:0] ctl_write_mask = 32'h0000_e0d3;

  // shared status field positions
  localparam int stat_event_lo = 16;
  localparam int stat_idle_bit = 13;
  localparam int stat_reference_supply_select_bit = 8;
  localparam int stat_output_lo = 0;
  localparam logic [31:0] stat_write_mask = 32'h0000_2100;

  // reference generator field positions
  localparam int ref_level_lo = 16;
  localparam int ref_enable_bit = 15;
  localparam int ref_pin_oe_bit = 8;
  localparam int ref_supply_lo = 0;
  localparam logic [31:0] ref_write_mask = 32'h001f_8103;

  // event edge selections
  typedef enum logic [1:0]
  {
    edge_off = 2'h0,
    edge_rise = 2'h1,
    edge_fall = 2'h2,
    edge_any = 2'h3
  } edge_sel_type;

  // negative input selections
  typedef enum logic [1:0]
  {
    neg_pin_b = 2'h0,
    neg_pin_c = 2'h1,
    neg_pin_d = 2'h2,
    neg_bandgap = 2'h3
  } neg_sel_type;

  // reference supply selections
  localparam logic [1:0] supply_ext_pin = 2'h1;
  localparam logic [1:0] supply_analog = 2'h3;

  // per-channel analog configuration toward the comparator core
  typedef struct packed
  {
    logic enable;
    logic polarity;
    logic pos_sel_ref;
    neg_sel_type neg_sel;
  } chan_cfg_type;

  // reference generator configuration toward the analog side
  typedef struct packed
  {
    logic enable;
    logic pin_oe;
    logic [4:0] level;
    logic [1:0] supply_sel;
    logic ext_ref_route;
  } ref_cfg_type;

endpackage

// ===== rtl/cmp_channel.sv
// one comparator channel: synchroniser, polarity, edge detect and event flag
`timescale 1ns/1ps
module cmp_channel
  import cmp_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // configuration
  input wire logic run_i,
  input wire logic polarity_i,
  input wire logic pin_oe_i,
  input wire logic [1:0] edge_sel_i,
  input wire logic event_clear_i,
  // analog side
  input wire logic raw_i,
  output logic pin_o,
  // status
  output logic out_o,
  output logic event_o,
  output logic irq_o
);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic event_ff;
  logic out_flag;
  logic rise;
  logic fall;
  logic hit;

  // raw result reaches the pin unsynchronised; off when the channel is disabled
  assign pin_o = pin_oe_i & run_i & (raw_i ^ polarity_i);

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_ff <= raw_i;
      sync2_ff <= sync1_ff;
    end
  end

  // core result is positive above negative; polarity inverts the sense
  assign out_flag = run_i & (sync2_ff ^ polarity_i);

  // previous output is cleared while halted, so a high output on resume counts as a rising edge
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      prev_ff <= 1'b0;
    else if (ce_i && run_i)
      prev_ff <= out_flag;
    else if (ce_i)
      prev_ff <= 1'b0;
  end

  assign rise = run_i & out_flag & ~prev_ff;
  assign fall = run_i & ~out_flag & prev_ff;

  always_comb
  begin
    unique case (edge_sel_type'(edge_sel_i))
      edge_any: hit = rise | fall;
      edge_fall: hit = polarity_i ? rise : fall;
      edge_rise: hit = polarity_i ? fall : rise;
      edge_off: hit = 1'b0;
    endcase
  end

  // set wins over a same-cycle software clear only while the flag is low; a hit on a set flag loses to the clear
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      event_ff <= 1'b0;
    else if (ce_i && hit && !event_ff)
      event_ff <= 1'b1;
    else if (ce_i && event_clear_i)
      event_ff <= 1'b0;
  end

  // a set flag suppresses further requests
  assign irq_o = ce_i & hit & ~event_ff;
  assign out_o = out_flag;
  assign event_o = event_ff;

endmodule

// ===== rtl/triple_comparator_control.sv
// register file, bus slave and channel glue for three analog comparators
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module triple_comparator_control
  import cmp_pkg::*;
#(
  parameter int channels = 3
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // device power state
  input wire logic idle_i,
  // analog comparator side
  input wire logic [channels-1:0] comparator_raw_i,
  output chan_cfg_type [channels-1:0] chan_cfg_o,
  output logic [channels-1:0] comparator_output_pin_o,
  output ref_cfg_type ref_cfg_o,
  // interrupt requests
  output logic [channels-1:0] irq_o
);

  logic [31:0] status_ff;
  logic [31:0] chan_ff [channels];
  logic [31:0] ref_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic req;
  logic hit_status;
  logic hit_ref;
  logic [channels-1:0] hit_chan;
  logic known;
  logic [3:0] alias_sel;
  logic [31:0] lane_mask;
  logic [31:0] rsel;
  logic halt;
  logic [channels-1:0] run;
  logic [channels-1:0] out_v;
  logic [channels-1:0] evt_v;
  logic [channels-1:0] evt_clear;
  logic [31:0] nxt_status;
  logic [31:0] nxt_ref;
  logic [31:0] nxt_chan [channels];

  // a new request is taken only while no ack is standing
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff & ce_i;
  assign alias_sel = wb_adr_i[3:0];
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // channel bases lie at 0x20 steps
  function automatic logic [15:0] chan_base(input int idx);
    chan_base = 16'(chan1_off + 16'(idx) * 16'h0020);
  endfunction

  always_comb
  begin
    hit_status = (wb_adr_i[15:4] == status_off[15:4]);
    hit_ref = (wb_adr_i[15:4] == refgen_off[15:4]);
    for (int i = 0; i < channels; i++)
      hit_chan[i] = (wb_adr_i[15:4] == chan_base(i)[15:4]);
    known = (hit_status | hit_ref | (|hit_chan)) & (wb_adr_i[1:0] == 2'h0);
  end

  // alias decode: plain, clear, set or invert of the written ones
  function automatic logic [31:0] apply_write(input logic [31:0] cur, input logic [31:0] mask,
                                              input logic [3:0] sel, input logic [31:0] dat);
    logic [31:0] m;
    logic [31:0] r;
    m = mask;
    r = cur;
    unique case (sel)
      alias_plain: r = (cur & ~m) | (dat & m);
      alias_clear: r = cur & ~(dat & m);
      alias_set: r = cur | (dat & m);
      alias_invert: r = cur ^ (dat & m);
      default: r = cur;
    endcase
    apply_write = r;
  endfunction

  // stop-in-idle halts every channel while the device idles
  assign halt = status_ff[stat_idle_bit] & idle_i;

  generate
    for (genvar g = 0; g < channels; g++)
    begin : gen_chan
      assign run[g] = chan_ff[g][ctl_enable_bit] & ~halt;
      assign chan_cfg_o[g].enable = run[g];
      assign chan_cfg_o[g].polarity = chan_ff[g][ctl_polarity_bit];
      assign chan_cfg_o[g].pos_sel_ref = chan_ff[g][ctl_pos_sel_bit];
      assign chan_cfg_o[g].neg_sel = neg_sel_type'(chan_ff[g][ctl_neg_sel_lo +: 2]);

      // software clears the flag through plain, clear-alias or invert-alias writes to bit 9
      assign evt_clear[g] = req & wb_we_i & known & hit_chan[g] & wb_sel_i[1] &
        (((alias_sel == alias_plain) & ~wb_dat_i[ctl_event_bit]) |
         ((alias_sel == alias_clear) & wb_dat_i[ctl_event_bit]) |
         ((alias_sel == alias_invert) & wb_dat_i[ctl_event_bit]));

      cmp_channel u_chan
      (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .run_i(run[g]),
        .polarity_i(chan_ff[g][ctl_polarity_bit]),
        .pin_oe_i(chan_ff[g][ctl_pin_oe_bit]),
        .edge_sel_i(chan_ff[g][ctl_edge_lo +: 2]),
        .event_clear_i(evt_clear[g]),
        .raw_i(comparator_raw_i[g]),
        .pin_o(comparator_output_pin_o[g]),
        .out_o(out_v[g]),
        .event_o(evt_v[g]),
        .irq_o(irq_o[g])
      );
    end
  endgenerate

  // reference generator outputs
  assign ref_cfg_o.enable = ref_ff[ref_enable_bit];
  assign ref_cfg_o.pin_oe = ref_ff[ref_pin_oe_bit];
  assign ref_cfg_o.level = ref_ff[ref_level_lo +: 5];
  assign ref_cfg_o.supply_sel = ref_ff[ref_supply_lo +: 2];
  assign ref_cfg_o.ext_ref_route = status_ff[stat_reference_supply_select_bit];

  // next register values; hardware-owned flags are merged at read time
  always_comb
  begin
    nxt_status = status_ff;
    nxt_ref = ref_ff;
    for (int i = 0; i < channels; i++)
      nxt_chan[i] = chan_ff[i];
    if (req && wb_we_i && known)
    begin
      if (hit_status)
        nxt_status = apply_write(status_ff, stat_write_mask & lane_mask, alias_sel, wb_dat_i);
      if (hit_ref)
        nxt_ref = apply_write(ref_ff, ref_write_mask & lane_mask, alias_sel, wb_dat_i);
      for (int i = 0; i < channels; i++)
        if (hit_chan[i])
          nxt_chan[i] = apply_write(chan_ff[i], ctl_write_mask & lane_mask, alias_sel, wb_dat_i);
    end
  end

  // configuration registers; masks keep unimplemented bits at zero
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      status_ff <= reg_reset;
      ref_ff <= reg_reset;
      for (int i = 0; i < channels; i++)
        chan_ff[i] <= reg_reset;
    end
    else if (ce_i)
    begin
      status_ff <= nxt_status;
      ref_ff <= nxt_ref;
      for (int i = 0; i < channels; i++)
        chan_ff[i] <= nxt_chan[i];
    end
  end

  // read view with live flags folded in
  always_comb
  begin
    rsel = 32'h0000_0000;
    if (hit_status)
    begin
      rsel = status_ff;
      rsel[stat_event_lo +: channels] = evt_v;
      rsel[stat_output_lo +: channels] = out_v;
    end
    if (hit_ref)
      rsel = ref_ff;
    for (int i = 0; i < channels; i++)
      if (hit_chan[i])
      begin
        rsel = chan_ff[i];
        rsel[ctl_event_bit] = evt_v[i];
        rsel[ctl_output_bit] = out_v[i];
      end
  end

  // one wait-free answer: ack or err the cycle after the request is taken
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ack_ff <= 1'b0;
      wb_err_o <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_ff <= req & known;
      wb_err_o <= req & ~known;
      if (req && known && !wb_we_i)
        rdata_ff <= rsel;
      else
        rdata_ff <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

endmodule

// ===== sim/cmp_analog_model.sv
// analog partner: comparator cores fed from pin levels
`timescale 1ns/1ps
module cmp_analog_model
  import cmp_pkg::*;
(
  // settings and pin levels
  input wire chan_cfg_type [2:0] cfg_i,
  input wire ref_cfg_type ref_i,
  input wire logic [2:0][3:0][7:0] pin_i,
  input wire logic [7:0] ext_i,
  // raw results
  output logic [2:0] raw_o
);
  localparam logic [7:0] gap = 8'h80;
  logic [7:0] pos;
  logic [7:0] neg;
  always_comb
  begin
    raw_o = '0;
    for (int c = 0; c < 3; c++)
    begin
      pos = cfg_i[c].pos_sel_ref ? (ref_i.ext_ref_route ? ext_i : gap) : pin_i[c][0];
      neg = (cfg_i[c].neg_sel == neg_bandgap) ? gap : pin_i[c][2'(cfg_i[c].neg_sel) + 2'h1];
      // a core that is off gives no trustworthy level, so it lies
      raw_o[c] = cfg_i[c].enable ? (pos > neg) : (pos <= neg);
    end
  end
endmodule

// ===== sim/triple_comparator_control_asserts.sv
// port assertions for the comparator control block
`timescale 1ns/1ps
module triple_comparator_control_asserts
  import cmp_pkg::*;
#(
  parameter int channels = 3
)
(
  // watched ports
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic idle_i,
  input wire logic [channels-1:0] comparator_raw_i,
  input wire chan_cfg_type [channels-1:0] chan_cfg_o,
  input wire logic [channels-1:0] comparator_output_pin_o,
  input wire ref_cfg_type ref_cfg_o,
  input wire logic [channels-1:0] irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_answer;
    wb_ack_o || wb_err_o;
  endsequence
  a_req_answer: assert property (s_take |=> s_answer) else $error("no bus answer");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !(wb_ack_o || wb_err_o))
    else $error("stray answer");
  a_resp_excl: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("data outside ack");
  a_pin_gate: assert property (!chan_cfg_o[0].enable |-> !comparator_output_pin_o[0])
    else $error("pin driven while off");
  a_irq_single: assert property (irq_o[0] |=> !irq_o[0]) else $error("irq repeated");
  // enabling with a high output may raise a request in the first running cycle
  a_irq_running: assert property (irq_o[0] |-> chan_cfg_o[0].enable)
    else $error("irq while off");
endmodule
bind triple_comparator_control triple_comparator_control_asserts #(.channels(channels)) u_asserts (
  .clock_i, .rst_b_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .idle_i, .comparator_raw_i, .chan_cfg_o,
  .comparator_output_pin_o, .ref_cfg_o, .irq_o);

// ===== sim/tb_triple_comparator_control.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_triple_comparator_control import cmp_pkg::*;;
  logic clock_i, rst_b_i, cyc, stb, we, idle, ack, err, erf;
  logic [15:0] adr;
  logic [31:0] dat, rdat, q;
  logic [2:0] raw, pin, irq;
  chan_cfg_type [2:0] cfg;
  ref_cfg_type rcfg;
  logic [2:0][3:0][7:0] volt;
  int error_cnt, n_compared, cyc_cnt, irq_cnt;
  logic [15:0] offs [5] = '{status_off, chan1_off, chan2_off, chan3_off, refgen_off};
  triple_comparator_control #(.channels(3)) uut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .idle_i(idle), .comparator_raw_i(raw), .chan_cfg_o(cfg),
    .comparator_output_pin_o(pin), .ref_cfg_o(rcfg), .irq_o(irq));
  cmp_analog_model u_model (.cfg_i(cfg), .ref_i(rcfg), .pin_i(volt), .ext_i(8'h40), .raw_o(raw));
  initial
  begin
    clock_i = 0;
    forever #20 clock_i = ~clock_i;
  end
  task end_of_test;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  // one classic cycle, entered just after a rising edge
  task bus(input logic [15:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clock_i);
    while (ack !== 1'b1 && err !== 1'b1)
      @(posedge clock_i);
    q = rdat;
    erf = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock_i);
  endtask
  // selected negative pin at mid level, the others on the wrong side
  task setv(input int c, input int n, input bit hi);
    for (int k = 1; k < 4; k++)
      volt[c][k] <= hi ? 8'hff : 8'h00;
    if (n < 3)
      volt[c][n+1] <= 8'h80;
    volt[c][0] <= hi ? 8'(8'h81 + $urandom % 100) : 8'(8'h7f - $urandom % 100);
  endtask
  function automatic int exp_evt(input int m, input bit rise);
    return int'(m == 3 || (m == 1 && rise) || (m == 2 && !rise));
  endfunction
  always @(posedge clock_i)
  begin
    cyc_cnt++;
    irq_cnt += $countones(irq);
    if (cyc_cnt == 6000)
    begin
      error_cnt++;
      end_of_test;
    end
  end
  initial
  begin
    int n, e1, e2, base, t;
    logic [31:0] r, m, v;
    rst_b_i = 0;
    {cyc, stb, we, idle, adr, dat, volt} = '0;
    void'($urandom(69763));
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i < 5; i++)
    begin
      bus(offs[i], 0, 0);
      chk(reg_reset, q);
    end
    bus(16'h2370, 0, 0);
    chk(1, erf);
    bus(16'h2312, 1, '1);
    chk(1, erf);
    for (int i = 1; i < 4; i++)
    begin
      bus(offs[i], 1, 32'hffff_7fff);
      bus(offs[i], 0, 0);
      chk(ctl_write_mask & 32'hffff_7fff, q);
      chk(5'h0f, cfg[i-1]);
    end
    bus(offs[4], 1, '1);
    bus(offs[4], 0, 0);
    chk(ref_write_mask, q);
    chk(5'h1f, rcfg.level);
    bus(offs[0], 1, '1);
    bus(offs[0], 0, 0);
    chk(stat_write_mask, q);
    chk(1, rcfg.ext_ref_route);
    m = ref_write_mask;
    for (int k = 0; k < 8; k++)
    begin
      r = $urandom;
      t = 1 + $urandom % 3;
      m = ref_write_mask & (t == 1 ? m & ~r : t == 2 ? m | r : m ^ r);
      bus(offs[4] + 16'(t * 4), 1, r);
      bus(offs[4], 0, 0);
      chk(m, q);
    end
    bus(offs[0], 1, 0);
    bus(offs[4], 1, 0);
    for (int c = 0; c < 3; c++)
      for (int e = 0; e < 4; e++)
        for (int p = 0; p < 2; p++)
        begin
          n = $urandom % 4;
          setv(c, n, 0);
          v = 32'(32'hc000 | p << 13 | e << 6 | n);
          bus(offs[c+1], 1, v);
          repeat (4) @(posedge clock_i);
          bus(offs[c+1], 1, v);
          base = irq_cnt;
          setv(c, n, 1);
          repeat (4) @(posedge clock_i);
          e1 = exp_evt(e, 1);
          bus(offs[0], 0, 0);
          chk(32'(e1) << (16 + c) | 32'(!p) << c, q);
          chk(32'(!p), pin[c]);
          setv(c, n, 0);
          repeat (4) @(posedge clock_i);
          e2 = e1 | exp_evt(e, 0);
          bus(offs[0], 0, 0);
          chk(32'(e2) << (16 + c) | 32'(p) << c, q);
          chk(32'(e2), 32'(irq_cnt - base));
          bus(offs[c+1], 1, 0);
        end
    bus(offs[1], 1, 32'h8000);
    for (int s = 0; s < 2; s++)
    begin
      bus(offs[0], 1, s ? 32'h2000 : 0);
      idle <= 1'b1;
      repeat (2) @(posedge clock_i);
      chk(32'(!s), cfg[0].enable);
      idle <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk(1, cfg[0].enable);
    end
    end_of_test;
  end
endmodule
